/* hw/opc_pkg.sv */
// Package with offsets, field layout and reset values of the output PLL config bank
package opc_pkg;
    localparam logic [15:0] OPC_ADDR_CP = 16'h0430;
    localparam logic [15:0] OPC_ADDR_FB = 16'h0431;
    localparam logic [15:0] OPC_ADDR_LF = 16'h0432;
    localparam logic [15:0] OPC_ADDR_PD = 16'h0433;
    localparam logic [7:0] OPC_RST_CP = 8'h2E;
    localparam logic [7:0] OPC_RST_FB = 8'h00;
    localparam logic [7:0] OPC_RST_LF = 8'h7F;
    localparam logic [7:0] OPC_RST_PD = 8'h00;
    localparam logic [7:0] OPC_MASK_CP = 8'h7F;
    localparam logic [7:0] OPC_MASK_FB = 8'hFF;
    localparam logic [7:0] OPC_MASK_LF = 8'hFF;
    localparam logic [7:0] OPC_MASK_PD = 8'h03;
    localparam int OPC_RP2_LSB = 6;
    localparam int OPC_RZ_LSB = 3;
    localparam int OPC_CP1_LSB = 0;
    localparam int OPC_PD_RST_BIT = 1;
    localparam int OPC_PD_BYP_BIT = 0;
    localparam logic [7:0] OPC_FB_MIN = 8'h0E;
    localparam logic [15:0] OPC_ZERO16 = 16'h0000;
endpackage

/* hw/opc_bus_if.sv */
// Interface carrying one register's write strobe, data and stored value
`timescale 1ns/1ps
`default_nettype none
interface opc_bus_if;
    logic we;
    logic [7:0] wdata;
    logic [7:0] q;
    modport ctrl (output we, output wdata, input q);
    modport reg_side (input we, input wdata, output q);
endinterface
`default_nettype wire

/* hw/opc_reg8.sv */
// One 8-bit configuration register with writable-bit mask
`timescale 1ns/1ps
`default_nettype none
module opc_reg8 #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic rst_n,
    opc_bus_if.reg_side bus
);
    logic [7:0] value;
    logic [7:0] next_value;

    always_comb begin
        next_value = value;
        if (bus.we) begin
            next_value = bus.wdata & WRITE_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= RESET_VALUE;
        end else begin
            value <= next_value;
        end
    end

    assign bus.q = value;
endmodule // opc_reg8
`default_nettype wire

/* hw/opc_top.sv */
// Configuration register bank of the first output analog PLL
// Notes on behaviour
// - Seven-bit charge pump code, resets 0x2E
// - Eight-bit feedback ratio, legal 14..255, resets 0
// - Bits 7:6 select second pole resistor
// - Bits 2:0 select pole capacitor, byte 0x7F
// - Set bit holds output post-divider in reset
// - Bypass bit forces internal zero resistor off
// - Reserved bits are zero after reset
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module opc_top
    import opc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic [6:0] CP_CURRENT,
    output logic [7:0] FB_RATIO,
    output logic FB_RATIO_LEGAL,
    output logic [1:0] RP2_SEL,
    output logic [2:0] RZ_SEL,
    output logic [2:0] CP1_SEL,
    output logic POST_DIV_RESET,
    output logic RZ_BYPASS
);
    // One carrier per register between decode and storage
    opc_bus_if cp_bus ();
    opc_bus_if fb_bus ();
    opc_bus_if lf_bus ();
    opc_bus_if pd_bus ();

    // Address decode for the write enables
    logic sel_cp;
    logic sel_fb;
    logic sel_lf;
    logic sel_pd;

    always_comb begin
        sel_cp = 1'b0;
        sel_fb = 1'b0;
        sel_lf = 1'b0;
        sel_pd = 1'b0;
        unique case (ADDR)
            OPC_ADDR_CP: sel_cp = 1'b1;
            OPC_ADDR_FB: sel_fb = 1'b1;
            OPC_ADDR_LF: sel_lf = 1'b1;
            OPC_ADDR_PD: sel_pd = 1'b1;
            default: sel_cp = 1'b0;
        endcase
    end

    assign cp_bus.we = WR && sel_cp;
    assign fb_bus.we = WR && sel_fb;
    assign lf_bus.we = WR && sel_lf;
    assign pd_bus.we = WR && sel_pd;

    // Every register sees the same write data
    assign cp_bus.wdata = WDATA;
    assign fb_bus.wdata = WDATA;
    assign lf_bus.wdata = WDATA;
    assign pd_bus.wdata = WDATA;

    opc_reg8 #(
        .RESET_VALUE(OPC_RST_CP),
        .WRITE_MASK(OPC_MASK_CP)
    ) u_cp (
        .clk(CLK),
        .rst_n(RST_N),
        .bus(cp_bus)
    );

    opc_reg8 #(
        .RESET_VALUE(OPC_RST_FB),
        .WRITE_MASK(OPC_MASK_FB)
    ) u_fb (
        .clk(CLK),
        .rst_n(RST_N),
        .bus(fb_bus)
    );

    opc_reg8 #(
        .RESET_VALUE(OPC_RST_LF),
        .WRITE_MASK(OPC_MASK_LF)
    ) u_lf (
        .clk(CLK),
        .rst_n(RST_N),
        .bus(lf_bus)
    );

    opc_reg8 #(
        .RESET_VALUE(OPC_RST_PD),
        .WRITE_MASK(OPC_MASK_PD)
    ) u_pd (
        .clk(CLK),
        .rst_n(RST_N),
        .bus(pd_bus)
    );

    // Read data registered one cycle after each RD cycle, zero after a cycle without RD
    logic [7:0] next_rdata;

    // readback, unmapped and reserved as zero
    always_comb begin
        next_rdata = 8'h00;
        if (RD) begin
            unique case (ADDR)
                OPC_ADDR_CP: next_rdata = cp_bus.q;
                OPC_ADDR_FB: next_rdata = fb_bus.q;
                OPC_ADDR_LF: next_rdata = lf_bus.q;
                OPC_ADDR_PD: next_rdata = pd_bus.q;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // Output registers mirror stored fields one cycle later
    logic [6:0] next_cp;

    always_comb begin
        next_cp = cp_bus.q[6:0];
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CP_CURRENT <= OPC_RST_CP[6:0];
        end else begin
            CP_CURRENT <= next_cp;
        end
    end

    // Ratio below the minimum is kept; only the flag drops
    logic [7:0] next_fb;
    logic next_fb_legal;

    always_comb begin
        next_fb = fb_bus.q;
        next_fb_legal = (fb_bus.q >= OPC_FB_MIN);
    end

    // ratio held until the next write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FB_RATIO <= OPC_RST_FB;
            FB_RATIO_LEGAL <= 1'b0;
        end else begin
            FB_RATIO <= next_fb;
            FB_RATIO_LEGAL <= next_fb_legal;
        end
    end

    // Loop filter byte split into its three selections
    logic [1:0] next_rp2;
    logic [2:0] next_rz;
    logic [2:0] next_cp1;

    always_comb begin
        next_rp2 = lf_bus.q[OPC_RP2_LSB +: 2];
        next_rz = lf_bus.q[OPC_RZ_LSB +: 3];
        next_cp1 = lf_bus.q[OPC_CP1_LSB +: 3];
    end

    // selections held until the next write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RP2_SEL <= OPC_RST_LF[OPC_RP2_LSB +: 2];
            RZ_SEL <= OPC_RST_LF[OPC_RZ_LSB +: 3];
            CP1_SEL <= OPC_RST_LF[OPC_CP1_LSB +: 3];
        end else begin
            RP2_SEL <= next_rp2;
            RZ_SEL <= next_rz;
            CP1_SEL <= next_cp1;
        end
    end

    // Post-divider control pair; upper bits never stored
    logic next_pd_rst;
    logic next_byp;

    always_comb begin
        next_pd_rst = pd_bus.q[OPC_PD_RST_BIT];
        next_byp = pd_bus.q[OPC_PD_BYP_BIT];
    end

    // control bits held until the next write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            POST_DIV_RESET <= OPC_RST_PD[OPC_PD_RST_BIT];
            RZ_BYPASS <= OPC_RST_PD[OPC_PD_BYP_BIT];
        end else begin
            POST_DIV_RESET <= next_pd_rst;
            RZ_BYPASS <= next_byp;
        end
    end
endmodule // opc_top
`default_nettype wire

/* bench/opc_top_monitor.sv */
// Checker for the config bank ports
`timescale 1ns/1ps
`default_nettype none
module opc_monitor
    import opc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic [6:0] CP_CURRENT,
    input wire logic [7:0] FB_RATIO,
    input wire logic FB_RATIO_LEGAL,
    input wire logic [1:0] RP2_SEL,
    input wire logic [2:0] RZ_SEL,
    input wire logic [2:0] CP1_SEL,
    input wire logic POST_DIV_RESET,
    input wire logic RZ_BYPASS
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence wr_s(a); WR && ADDR == a; endsequence
    cp_wr_a: assert property (wr_s(OPC_ADDR_CP) |-> ##2 CP_CURRENT == $past(WDATA[6:0], 2)) else $error("cp");
    fb_wr_a: assert property (wr_s(OPC_ADDR_FB) |-> ##2 FB_RATIO == $past(WDATA, 2)) else $error("fb");
    lf_wr_a: assert property (wr_s(OPC_ADDR_LF) |-> ##2 {RP2_SEL, RZ_SEL, CP1_SEL} == $past(WDATA, 2)) else $error("lf");
    pd_wr_a: assert property (wr_s(OPC_ADDR_PD) |-> ##2 {POST_DIV_RESET, RZ_BYPASS} == $past(WDATA[1:0], 2)) else $error("pd");
    fields_hold_a: assert property (!WR |-> ##2 $stable({CP_CURRENT, FB_RATIO, FB_RATIO_LEGAL,
        RP2_SEL, RZ_SEL, CP1_SEL, POST_DIV_RESET, RZ_BYPASS})) else $error("hold");
    ratio_legal_a: assert property (FB_RATIO_LEGAL == (FB_RATIO >= OPC_FB_MIN)) else $error("legal");
    rdata_idle_a: assert property (!RD |=> RDATA == 8'h00) else $error("idle");
    unmapped_rd_a: assert property (RD && ADDR[15:2] != 14'h010C |=> RDATA == 8'h00) else $error("unmapped");
endmodule // opc_monitor
bind opc_top opc_monitor i_mon (.*);
`default_nettype wire

/* bench/tb_output_pll_config_regs.sv */
// Self-checking bench for the config bank
`timescale 1ns/1ps
`default_nettype none
module tb_output_pll_config_regs;
    import opc_pkg::*;
    logic CLK = 0, RST_N = 0, WR = 0, RD = 0, FB_RATIO_LEGAL, POST_DIV_RESET, RZ_BYPASS;
    logic [15:0] ADDR = 16'h0000;
    logic [7:0] WDATA = 8'h00, RDATA, FB_RATIO, v, sh [4];
    logic [6:0] CP_CURRENT;
    logic [1:0] RP2_SEL;
    logic [2:0] RZ_SEL, CP1_SEL;
    int err_count = 0, samples_checked = 0;
    logic [31:0] seed = 32'h0000_0029;
    opc_top i_dut (.*);
    always #10 CLK = ~CLK;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic rw(logic [15:0] a, logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        if (a[15:2] == 14'h010C) sh[a[1:0]] = d & (a[1:0] == 2'h0 ? 8'h7F : a[1:0] == 2'h3 ? 8'h03 : 8'hFF);
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
        check(v, a[15:2] == 14'h010C ? sh[a[1:0]] : 8'h00);
        check({1'b0, CP_CURRENT}, sh[0]);
        check(FB_RATIO, sh[1]);
        check({7'h00, FB_RATIO_LEGAL}, {7'h00, sh[1] >= OPC_FB_MIN});
        check({RP2_SEL, RZ_SEL, CP1_SEL}, sh[2]);
        check({6'h00, POST_DIV_RESET, RZ_BYPASS}, sh[3]);
    endtask
    initial begin
        sh = '{8'h2E, 8'h00, 8'h7F, 8'h00};
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 4; i++) rw(16'h042C + 16'(i), 8'hFF);
        $display("reset test done");
        for (int i = 0; i < 4; i++) rw(OPC_ADDR_CP + 16'(i), 8'hFF);
        rw(OPC_ADDR_FB, 8'h0D);
        rw(OPC_ADDR_FB, 8'h0E);
        rw(16'h0434, 8'hFF);
        $display("corner test done");
        for (int i = 0; i < 200; i++) begin
            logic [15:0] a;
            logic [7:0] d;
            a = 16'h042F + 16'(rnd() % 6);
            d = 8'(rnd());
            if (a == OPC_ADDR_FB && d < OPC_FB_MIN) d = d + OPC_FB_MIN;
            rw(a, d);
        end
        $display("random test done");
        RST_N <= 1'b0;
        sh = '{8'h2E, 8'h00, 8'h7F, 8'h00};
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        rw(16'h042F, 8'hFF);
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule // tb_output_pll_config_regs
`default_nettype wire
